// File: hdl/atd_cfg.svh
/*
  Constants of the transfer descriptor decoder: register offsets, descriptor
  field positions, codes and reset values. Assumes a 32-bit Wishbone slave
  with byte addresses and a 10 MHz clock.
*/
`ifndef ATD_CFG_SVH
`define ATD_CFG_SVH

`define ADR_DESC_DW0 8'h00
`define ADR_DESC_DW1 8'h04
`define ADR_DESC_DW2 8'h08
`define ADR_STATUS 8'h0c
`define ADR_IRQ_CLR 8'h10
`define ADR_IRQ_EN 8'h14
`define ADR_PROGRESS 8'h18

`define ST_DONE 0
`define ST_FATAL 1
`define ST_FORMAT 2
`define ST_BITS 3

`define DW0_VALID 0
`define DW0_LEN_LSB 3
`define DW0_MAXP_LSB 18
`define DW0_MULT_LSB 29
`define DW0_EP0 31
`define DW1_EP_LSB 0
`define DW1_FUNC_LSB 3
`define DW1_TOKEN_LSB 10
`define DW1_TYPE_LSB 12
`define DW1_SPLIT 14
`define DW1_RSVD_LSB 15
`define DW2_PTR_LSB 8
`define DW2_RSVD_BIT 24

`define TYPE_CONTROL 2'h0
`define TYPE_BULK 2'h2
`define BULK_MAX_BYTES 11'h200
`define RAM_BASE 16'h0400
`define RAM_UNIT_SHIFT 3

`define RST_WORD 32'h0000_0000
`define RST_STATUS 3'h0

`endif

// File: hdl/atd_pkg.sv
/*
  Types shared by the descriptor decoder files.
  Assumes atd_cfg.svh holds the numeric constants.
*/
package atd_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_WAIT = 3'b010,
    S_DRAIN = 3'b011,
    S_FINISH = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    TOK_OUT = 2'b00,
    TOK_IN = 2'b01,
    TOK_SETUP = 2'b10,
    TOK_PING = 2'b11
  } token_t;
endpackage

// File: hdl/desc_if.sv
/*
  Carries the raw descriptor words and their decoded fields between the
  engine and the field decoder. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface desc_if;
  import atd_pkg::*;
  logic [31:0] dw0;
  logic [31:0] dw1;
  logic [31:0] dw2;
  logic valid;
  logic split;
  logic [1:0] xtype;
  token_t token;
  logic [6:0] func;
  logic [3:0] ep;
  logic [1:0] mult;
  logic [10:0] max_pkt;
  logic [14:0] len;
  logic [15:0] ptr;
  logic fmt_err;
  modport src (output dw0, dw1, dw2, input valid, split, xtype, token, func, ep,
    mult, max_pkt, len, ptr, fmt_err);
  modport dec (input dw0, dw1, dw2, output valid, split, xtype, token, func, ep,
    mult, max_pkt, len, ptr, fmt_err);
endinterface

// File: hdl/desc_decode.sv
/*
  Splits the three descriptor words into fields and flags a descriptor that
  software built against the format. Purely combinational.
*/
`timescale 1ns/1ps
`include "atd_cfg.svh"
module desc_decode
  import atd_pkg::*;
(
  desc_if.dec d
);
  always_comb begin
    d.valid = d.dw0[`DW0_VALID];
    d.len = d.dw0[`DW0_LEN_LSB +: 15];
    d.max_pkt = d.dw0[`DW0_MAXP_LSB +: 11];
    d.mult = d.dw0[`DW0_MULT_LSB +: 2];
    d.ep = {d.dw1[`DW1_EP_LSB +: 3], d.dw0[`DW0_EP0]};
    d.func = d.dw1[`DW1_FUNC_LSB +: 7];
    d.token = token_t'(d.dw1[`DW1_TOKEN_LSB +: 2]);
    d.xtype = d.dw1[`DW1_TYPE_LSB +: 2];
    d.split = d.dw1[`DW1_SPLIT];
    d.ptr = d.dw2[`DW2_PTR_LSB +: 16];
    d.fmt_err = 1'b0;
    if (d.dw2[`DW2_RSVD_BIT] || (d.dw1[31:`DW1_RSVD_LSB] != 17'h0)) begin
      d.fmt_err = 1'b1;
    end
    if (d.mult == 2'h0) begin
      d.fmt_err = 1'b1;
    end
    if (d.token == TOK_PING) begin
      d.fmt_err = 1'b1;
    end
    if ((d.xtype != `TYPE_CONTROL) && (d.xtype != `TYPE_BULK)) begin
      d.fmt_err = 1'b1;
    end
    if ((d.xtype == `TYPE_BULK) && (d.max_pkt > `BULK_MAX_BYTES)) begin
      d.fmt_err = 1'b1;
    end
  end
endmodule // desc_decode

// File: hdl/atd_top.sv
/*
  Asynchronous transfer descriptor engine: a Wishbone register file holding
  one descriptor, its execution as a series of packet requests toward the
  link, and sticky event status with an interrupt. Assumes the link side
  answers each request with a level handshake on PKT_ACK from another clock.
*/
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "atd_cfg.svh"
module atd_top
  import atd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ,
  output logic PKT_REQ,
  output logic [1:0] PKT_PID,
  output logic PKT_SPLIT,
  output logic PKT_BULK,
  output logic [6:0] PKT_FUNC,
  output logic [3:0] PKT_EP,
  output logic [15:0] PKT_RAM_ADDR,
  output logic [10:0] PKT_BYTES,
  input wire logic PKT_ACK,
  input wire logic PKT_FATAL
);
  desc_if d ();

  desc_decode u_decode (
    .d(d)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [10:0] take_bytes(input logic [10:0] max_p,
      input logic [14:0] rem);
    return ({4'h0, max_p} < rem) ? max_p : rem[10:0];
  endfunction

  // two-flop synchronisers for link-side inputs
  logic ack_m_r, ack_s_r, fat_m_r, fat_s_r;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      fat_m_r <= 1'b0;
      fat_s_r <= 1'b0;
    end else begin
      ack_m_r <= PKT_ACK;
      ack_s_r <= ack_m_r;
      fat_m_r <= PKT_FATAL;
      fat_s_r <= fat_m_r;
    end
  end

  logic [31:0] dw0_r, dw0_nxt, dw1_r, dw1_nxt, dw2_r, dw2_nxt;
  logic [`ST_BITS-1:0] status_r, status_nxt, en_r, en_nxt, st_set;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt, irq_r, irq_nxt;
  state_t state_r, state_nxt;
  logic [14:0] moved_r, moved_nxt;
  logic [1:0] pkts_r, pkts_nxt;
  logic abort_r, abort_nxt;
  logic req_r, req_nxt, split_r, split_nxt, bulk_r, bulk_nxt;
  logic [1:0] pid_r, pid_nxt;
  logic [6:0] func_r, func_nxt;
  logic [3:0] ep_r, ep_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [10:0] bytes_r, bytes_nxt;
  logic take, wr_now, clr_valid;

  assign d.dw0 = dw0_r;
  assign d.dw1 = dw1_r;
  assign d.dw2 = dw2_r;

  // request taken on first strobe edge, write lands when ack is sampled
  assign take = CYC_I && STB_I && !ack_r;
  assign wr_now = CYC_I && STB_I && ack_r && WE_I;

  // execution engine
  always_comb begin
    state_nxt = state_r;
    moved_nxt = moved_r;
    pkts_nxt = pkts_r;
    abort_nxt = abort_r;
    req_nxt = req_r;
    split_nxt = split_r;
    bulk_nxt = bulk_r;
    pid_nxt = pid_r;
    func_nxt = func_r;
    ep_nxt = ep_r;
    addr_nxt = addr_r;
    bytes_nxt = bytes_r;
    clr_valid = 1'b0;
    st_set = '0;
    case (state_r)
      S_IDLE: begin
        if (d.valid) begin
          if (d.fmt_err) begin
            clr_valid = 1'b1;
            st_set[`ST_FORMAT] = 1'b1;
          end else begin
            moved_nxt = 15'h0;
            pkts_nxt = 2'h0;
            abort_nxt = 1'b0;
            state_nxt = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        if ((moved_r == d.len) || (pkts_r == d.mult)) begin
          state_nxt = S_FINISH;
        end else begin
          req_nxt = 1'b1;
          split_nxt = d.split;
          bulk_nxt = (d.xtype == `TYPE_BULK);
          pid_nxt = d.token;
          func_nxt = d.func;
          ep_nxt = d.ep;
          addr_nxt = d.ptr + {4'h0, moved_r[14:`RAM_UNIT_SHIFT]};
          bytes_nxt = take_bytes(d.max_pkt, d.len - moved_r);
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (ack_s_r) begin
          req_nxt = 1'b0;
          if (fat_s_r) begin
            clr_valid = 1'b1;
            abort_nxt = 1'b1;
            st_set[`ST_FATAL] = 1'b1;
          end else begin
            moved_nxt = moved_r + {4'h0, bytes_r};
            pkts_nxt = pkts_r + 2'h1;
          end
          state_nxt = S_DRAIN;
        end
      end
      S_DRAIN: begin
        // wait for the link to drop ack so one answer never counts twice
        if (!ack_s_r) begin
          state_nxt = abort_r ? S_IDLE : S_CHECK;
        end
      end
      S_FINISH: begin
        clr_valid = 1'b1;
        st_set[`ST_DONE] = 1'b1;
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // register file and bus slave
  always_comb begin
    dw0_nxt = dw0_r;
    dw1_nxt = dw1_r;
    dw2_nxt = dw2_r;
    en_nxt = en_r;
    status_nxt = status_r;
    ack_nxt = take;
    dat_nxt = dat_r;
    // descriptor is frozen while the engine owns it
    if (wr_now && (state_r == S_IDLE)) begin
      if (ADR_I == `ADR_DESC_DW0) begin
        dw0_nxt = merge_bytes(dw0_r, DAT_I, SEL_I);
      end else if (ADR_I == `ADR_DESC_DW1) begin
        dw1_nxt = merge_bytes(dw1_r, DAT_I, SEL_I);
      end else if (ADR_I == `ADR_DESC_DW2) begin
        dw2_nxt = merge_bytes(dw2_r, DAT_I, SEL_I);
      end
    end
    if (wr_now && (ADR_I == `ADR_IRQ_EN) && SEL_I[0]) begin
      en_nxt = DAT_I[`ST_BITS-1:0];
    end
    if (wr_now && (ADR_I == `ADR_IRQ_CLR) && SEL_I[0]) begin
      status_nxt = status_r & ~DAT_I[`ST_BITS-1:0];
    end
    // set wins over a clear in the same cycle
    status_nxt = status_nxt | st_set;
    if (clr_valid) begin
      dw0_nxt[`DW0_VALID] = 1'b0;
    end
    if (take) begin
      if (ADR_I == `ADR_DESC_DW0) begin
        dat_nxt = dw0_r;
      end else if (ADR_I == `ADR_DESC_DW1) begin
        dat_nxt = dw1_r;
      end else if (ADR_I == `ADR_DESC_DW2) begin
        dat_nxt = dw2_r;
      end else if (ADR_I == `ADR_STATUS) begin
        dat_nxt = {29'h0, status_r};
      end else if (ADR_I == `ADR_IRQ_EN) begin
        dat_nxt = {29'h0, en_r};
      end else if (ADR_I == `ADR_PROGRESS) begin
        dat_nxt = {12'h0, state_r, pkts_r, moved_r};
      end else begin
        dat_nxt = 32'h0;
      end
    end
    irq_nxt = |(status_r & en_r);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      dw0_r <= `RST_WORD;
      dw1_r <= `RST_WORD;
      dw2_r <= `RST_WORD;
      status_r <= `RST_STATUS;
      en_r <= `RST_STATUS;
      dat_r <= 32'h0;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      state_r <= S_IDLE;
      moved_r <= 15'h0;
      pkts_r <= 2'h0;
      abort_r <= 1'b0;
      req_r <= 1'b0;
      split_r <= 1'b0;
      bulk_r <= 1'b0;
      pid_r <= 2'h0;
      func_r <= 7'h0;
      ep_r <= 4'h0;
      addr_r <= 16'h0;
      bytes_r <= 11'h0;
    end else begin
      dw0_r <= dw0_nxt;
      dw1_r <= dw1_nxt;
      dw2_r <= dw2_nxt;
      status_r <= status_nxt;
      en_r <= en_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      state_r <= state_nxt;
      moved_r <= moved_nxt;
      pkts_r <= pkts_nxt;
      abort_r <= abort_nxt;
      req_r <= req_nxt;
      split_r <= split_nxt;
      bulk_r <= bulk_nxt;
      pid_r <= pid_nxt;
      func_r <= func_nxt;
      ep_r <= ep_nxt;
      addr_r <= addr_nxt;
      bytes_r <= bytes_nxt;
    end
  end

  assign DAT_O = dat_r;
  assign ACK_O = ack_r;
  assign IRQ = irq_r;
  assign PKT_REQ = req_r;
  assign PKT_PID = pid_r;
  assign PKT_SPLIT = split_r;
  assign PKT_BULK = bulk_r;
  assign PKT_FUNC = func_r;
  assign PKT_EP = ep_r;
  assign PKT_RAM_ADDR = addr_r;
  assign PKT_BYTES = bytes_r;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_issue;
    state_r == S_CHECK ##1 req_r;
  endsequence

  sequence s_answer;
    req_r && ack_s_r && !fat_s_r;
  endsequence

  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("bus ack held longer than one cycle");
  a_pkt_ram_addr: assert property (s_issue |-> PKT_RAM_ADDR ==
      d.ptr + {4'h0, moved_r[14:3]})
    else $error("packet address not pointer plus moved units");
  a_split_follows: assert property (s_issue |-> PKT_SPLIT == dw1_r[14])
    else $error("split output differs from descriptor");
  a_bulk_decode: assert property (s_issue |-> PKT_BULK == (dw1_r[13:12] == 2'b10))
    else $error("bulk flag wrong for transfer type");
  a_no_sw_ping: assert property (req_r |-> PKT_PID != 2'b11)
    else $error("ping issued from a software token");
  a_func_addr: assert property (s_issue |-> PKT_FUNC == dw1_r[9:3])
    else $error("function address mismatch");
  a_endpoint_join: assert property (s_issue |-> PKT_EP == {dw1_r[2:0], dw0_r[31]})
    else $error("endpoint number assembled wrongly");
  a_mult_bound: assert property (s_issue |-> pkts_r < dw0_r[30:29])
    else $error("more packets than multiplier");
  a_pkt_size: assert property (req_r |-> PKT_BYTES <= dw0_r[28:18])
    else $error("packet larger than max packet length");
  a_len_bound: assert property (s_answer |=>
      moved_r <= dw0_r[17:3])
    else $error("moved bytes exceed transfer length");
  a_valid_clear: assert property (state_r == S_FINISH |=>
      !dw0_r[0] && status_r[0])
    else $error("valid not cleared at completion");
  a_idle_waits: assert property (state_r == S_IDLE && !dw0_r[0] |=>
      state_r == S_IDLE && !req_r)
    else $error("engine left idle without valid");
  a_req_holds: assert property (req_r && !ack_s_r |=> req_r && $stable(PKT_BYTES))
    else $error("request dropped before answer");
endmodule // atd_top

// File: bench/link_partner.sv
/*
  Link-side responder for the packet handshake of the descriptor engine.
  Assumes PKT_REQ is held until PKT_ACK is seen, as a four-phase handshake.
*/
`timescale 1ns/1ps
module link_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [3:0] delay,
  input wire logic fail,
  output logic ack,
  output logic fatal
);
  logic [3:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      fatal <= 1'b0;
      cnt <= 4'h0;
    end else if (req && !ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay) begin
        ack <= 1'b1;
        fatal <= fail;
        cnt <= 4'h0;
      end
    end else if (!req && ack) begin
      ack <= 1'b0;
      // released: the fatal result is inverted, not cleared
      fatal <= ~fatal;
    end
  end
endmodule // link_partner

// File: bench/tb_async_transfer_descriptor_decode.sv
/*
  Self-checking bench for the descriptor engine: Wishbone driver, packet
  scoreboard and link partner. Assumes atd_top and atd_cfg.svh.
*/
`timescale 1ns/1ps
`include "atd_cfg.svh"
module tb_async_transfer_descriptor_decode;
  import atd_pkg::*;
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic WE_I = 1'b0;
  logic [7:0] ADR_I = 8'h00;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0;
  logic [31:0] DAT_O;
  logic ACK_O, IRQ, PKT_REQ, PKT_SPLIT, PKT_BULK, PKT_ACK, PKT_FATAL;
  logic [1:0] PKT_PID;
  logic [6:0] PKT_FUNC;
  logic [3:0] PKT_EP;
  logic [15:0] PKT_RAM_ADDR;
  logic [10:0] PKT_BYTES;
  logic [3:0] dly = 4'h0;
  logic fail = 1'b0;
  logic req_q = 1'b0;
  logic [2:0] en = 3'h0;
  logic [47:0] exp_q[$];
  logic [95:0] bad [6];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 99531;

  always #50 CLOCK = ~CLOCK;

  atd_top atd_top_inst (.CLOCK(CLOCK), .NRST(NRST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .IRQ(IRQ), .PKT_REQ(PKT_REQ), .PKT_PID(PKT_PID),
    .PKT_SPLIT(PKT_SPLIT), .PKT_BULK(PKT_BULK), .PKT_FUNC(PKT_FUNC), .PKT_EP(PKT_EP),
    .PKT_RAM_ADDR(PKT_RAM_ADDR), .PKT_BYTES(PKT_BYTES), .PKT_ACK(PKT_ACK),
    .PKT_FATAL(PKT_FATAL));
  link_partner link_partner_inst (.clk(CLOCK), .rst_n(NRST), .req(PKT_REQ),
    .delay(dly), .fail(fail), .ack(PKT_ACK), .fatal(PKT_FATAL));

  task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // scoreboard: every new request must match the oldest note
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
    req_q <= PKT_REQ;
    if (PKT_REQ === 1'b1 && req_q !== 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected packet", 48'h1, 48'h0);
      else
        check("packet", {6'h0, PKT_PID, PKT_SPLIT, PKT_BULK, PKT_FUNC, PKT_EP, PKT_RAM_ADDR,
        PKT_BYTES}, exp_q.pop_front());
    end
  end

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
    int i;
    @(posedge CLOCK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= dat;
    SEL_I <= 4'hf;
    i = 0;
    do begin
      @(posedge CLOCK);
      i++;
    end while (ACK_O !== 1'b1 && i < 50);
    rd = DAT_O;
    if (ACK_O !== 1'b1)
      check("bus ack", 48'h0, 48'h1);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask

  task rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0, r);
    check(what, {16'h0, r}, {16'h0, exp});
  endtask

  // waits until the engine is back in idle with valid cleared
  task idle;
    logic [31:0] a, b;
    int i;
    for (i = 0; i < 300; i++) begin
      wb(1'b0, `ADR_DESC_DW0, 32'h0, a);
      wb(1'b0, `ADR_PROGRESS, 32'h0, b);
      if (a[0] === 1'b0 && b[19:17] === 3'h0)
        break;
    end
  endtask

  task go(input logic [31:0] w0, w1, w2, input logic [2:0] st);
    logic [31:0] r;
    wb(1'b1, `ADR_DESC_DW2, w2, r);
    wb(1'b1, `ADR_DESC_DW1, w1, r);
    wb(1'b1, `ADR_DESC_DW0, w0, r);
    idle();
    rdchk(`ADR_DESC_DW0, w0 & 32'hffff_fffe, "valid");
    rdchk(`ADR_STATUS, {29'h0, st}, "status");
    check("irq", 48'(IRQ), 48'(|(st & en)));
    check("leftover", 48'(exp_q.size()), 48'h0);
    wb(1'b1, `ADR_IRQ_CLR, 32'h7, r);
    rdchk(`ADR_STATUS, 32'h0, "cleared");
    check("irq low", 48'(IRQ), 48'h0);
  endtask

  task run(input logic [1:0] tok, typ, input logic sp, input logic [6:0] fn,
      input logic [3:0] ep, input logic [1:0] mult, input logic [10:0] maxp,
      input logic [14:0] len, input logic [15:0] cpu, input int cap, input logic [2:0] st);
    logic [15:0] ptr;
    logic [14:0] mv, n;
    int p;
    // pointer derived from the cpu view
    ptr = (cpu - `RAM_BASE) >> `RAM_UNIT_SHIFT;
    mv = 15'h0;
    for (p = 0; p < mult && p < cap && mv < len; p++) begin
      n = (len - mv > 15'(maxp)) ? 15'(maxp) : len - mv;
      exp_q.push_back({6'h0, tok, sp, typ == `TYPE_BULK, fn, ep, ptr + {4'h0, mv[14:3]},
        n[10:0]});
      mv = mv + n;
    end
    // valid set only once the words are in place
    go({ep[0], mult, maxp, len, 3'h1}, {17'h0, sp, typ, tok, fn, ep[3:1]}, {8'h0, ptr, 8'h0}, st);
  endtask

  initial begin
    logic [31:0] r;
    int k;
    bad = '{{32'h0004_0000, 64'h0}, {32'h2000_0000, 64'h0}, {32'h0, 32'h0000_0c00, 32'h0},
      {32'h0, 32'h0000_1000, 32'h0}, {32'h0, 32'h0010_0000, 32'h0}, {64'h0, 32'h0100_0000}};
    repeat (8) @(posedge CLOCK);
    NRST <= 1'b1;
    rdchk(`ADR_STATUS, {29'h0, `RST_STATUS}, "status reset");
    rdchk(`ADR_PROGRESS, 32'h0, "progress reset");
    rdchk(`ADR_DESC_DW0, `RST_WORD, "dw0 reset");
    rdchk(8'h1c, 32'h0, "unmapped");
    wb(1'b1, `ADR_STATUS, 32'h7, r);
    rdchk(`ADR_STATUS, 32'h0, "status read only");
    wb(1'b1, `ADR_IRQ_EN, 32'h7, r);
    en <= 3'h7;
    run(TOK_OUT, `TYPE_BULK, 1'b0, 7'h05, 4'h9, 2'h3, 11'h200, 15'd1100, 16'h1000, 3,
      3'b001);
    for (k = 0; k < 6; k++) begin
      dly <= 4'($random(seed));
      run(2'(k % 3), (k < 3) ? `TYPE_CONTROL : `TYPE_BULK, k[0], 7'($random(seed)),
        4'($random(seed)), 2'(k % 3 + 1), 11'h040, 15'($random(seed)) & 15'h01ff,
        16'h0400 + {5'h0, 8'($random(seed)), 3'h0}, 3, 3'b001);
    end
    run(TOK_IN, `TYPE_CONTROL, 1'b1, 7'h7f, 4'hf, 2'h1, 11'h040, 15'h7fff, 16'h0400, 3,
      3'b001);
    run(TOK_SETUP, `TYPE_CONTROL, 1'b0, 7'h00, 4'h0, 2'h3, 11'h008, 15'h0, 16'h0400, 3,
      3'b001);
    for (k = 0; k < 6; k++)
      go({1'b0, 2'h1, 11'h200, 15'h0040, 3'h1} ^ bad[k][95:64], 32'h0000_2008 ^ bad[k][63:32],
        32'h0000_1000 ^ bad[k][31:0], 3'b100);
    go({1'b0, 2'h1, 11'h200, 15'h0040, 3'h0}, 32'h0000_2008, 32'h0000_1000, 3'b000);
    fail <= 1'b1;
    run(TOK_OUT, `TYPE_BULK, 1'b0, 7'h11, 4'h2, 2'h2, 11'h200, 15'd1100, 16'h2000, 1,
      3'b010);
    fail <= 1'b0;
    wb(1'b1, `ADR_IRQ_EN, 32'h0, r);
    en <= 3'h0;
    run(TOK_IN, `TYPE_BULK, 1'b0, 7'h22, 4'h3, 2'h1, 11'h100, 15'h0010, 16'h0408, 3, 3'b001);
    conclude();
  end
endmodule // tb_async_transfer_descriptor_decode
